//--- core/tpic_timer_capture.sv
// Purpose: Timer pair (16/32-bit) with input capture channels
// Assumes: aclk is the instruction clock; pins are asynchronous
// Notes: Reading a capture buffer word pops the FIFO
`timescale 1ns/10ps
module tpic_timer_capture
  import tpic_pkg::*;
#(
  parameter int NCAP = 2
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic lower_ext_clock_pin,
  input wire logic upper_ext_clock_pin,
  input wire logic [NCAP-1:0] capture_pin,
  output logic wake_req
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_have_reg, w_have_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire, rd_fire, wr_hit;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [15:0] lower_ctrl_reg, upper_ctrl_reg;
  logic [15:0] lower_count, upper_count;
  logic [15:0] lower_period, upper_period;
  logic lower_flag_reg, upper_flag_reg;
  logic [NCAP-1:0] cap_flag_reg;
  logic [7:0] lower_pre_reg, upper_pre_reg;
  logic [2:0] lpin_sync, upin_sync;
  logic lpin_lvl, upin_lvl;
  logic lpin_rise, upin_rise;
  logic cascade_sel, lower_src, upper_src, lower_tick, upper_tick;
  logic lower_step, upper_step, lower_match, upper_match;
  logic [NCAP-1:0] cap_wake;
  logic [15:0] cap_ctrl_rd [NCAP];
  logic [15:0] cap_buf_rd [NCAP];

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Prescaler terminal count per divide field
  function automatic logic [7:0] div_limit(input logic [1:0] sel);
    case (sel)
      2'h3: div_limit = DIV256_LIM;
      2'h2: div_limit = DIV64_LIM;
      2'h1: div_limit = DIV8_LIM;
      default: div_limit = DIV1_LIM;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_have_reg;
  assign s_axi_wready = ~w_have_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & ~s_axi_rvalid;

  // Write address and data latches, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_reg)
      begin
        aw_have_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_reg <= 1'b0;
      if (s_axi_wvalid && !w_have_reg)
      begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_reg <= 1'b0;
    end
  end

  // Write decode for the response code
  always_comb
  begin
    wr_hit = (waddr_reg == LOWER_CTRL_OFS) || (waddr_reg == UPPER_CTRL_OFS)
      || (waddr_reg == LOWER_COUNT_OFS) || (waddr_reg == UPPER_COUNT_OFS)
      || (waddr_reg == LOWER_PERIOD_OFS) || (waddr_reg == UPPER_PERIOD_OFS)
      || (waddr_reg == STATUS_OFS);
    for (int i = 0; i < NCAP; i++)
      if (waddr_reg == CAP_BASE_OFS + 8'(i) * CAP_STRIDE)
        wr_hit = 1'b1;
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read data selection
  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      LOWER_CTRL_OFS: rd_mux[15:0] = lower_ctrl_reg;
      UPPER_CTRL_OFS: rd_mux[15:0] = upper_ctrl_reg;
      LOWER_COUNT_OFS: rd_mux[15:0] = lower_count;
      UPPER_COUNT_OFS: rd_mux[15:0] = upper_count;
      LOWER_PERIOD_OFS: rd_mux[15:0] = lower_period;
      UPPER_PERIOD_OFS: rd_mux[15:0] = upper_period;
      STATUS_OFS:
      begin
        rd_mux[LOWER_FLAG_BIT] = lower_flag_reg;
        rd_mux[UPPER_FLAG_BIT] = upper_flag_reg;
        rd_mux[CAP_FLAG_BIT +: NCAP] = cap_flag_reg;
      end
      default: rd_hit = 1'b0;
    endcase
    for (int i = 0; i < NCAP; i++)
    begin
      if (s_axi_araddr == CAP_BASE_OFS + 8'(i) * CAP_STRIDE)
      begin
        rd_hit = 1'b1;
        rd_mux[15:0] = cap_ctrl_rd[i];
      end
      if (s_axi_araddr == CAP_BASE_OFS + 8'(i) * CAP_STRIDE + CAP_BUF_OFS)
      begin
        rd_hit = 1'b1;
        rd_mux[15:0] = cap_buf_rd[i];
      end
    end
  end

  // Read response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Timer control registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lower_ctrl_reg <= CTRL_RST;
      upper_ctrl_reg <= CTRL_RST;
      lower_period <= PERIOD_RST;
      upper_period <= PERIOD_RST;
    end
    else if (wr_fire)
    begin
      if (waddr_reg == LOWER_CTRL_OFS)
        lower_ctrl_reg <= merge16(lower_ctrl_reg, wdata_reg, wstrb_reg)
          & LOWER_CTRL_MASK;
      if (waddr_reg == UPPER_CTRL_OFS)
        upper_ctrl_reg <= merge16(upper_ctrl_reg, wdata_reg, wstrb_reg)
          & UPPER_CTRL_MASK;
      if (waddr_reg == LOWER_PERIOD_OFS)
        lower_period <= merge16(lower_period, wdata_reg, wstrb_reg);
      if (waddr_reg == UPPER_PERIOD_OFS)
        upper_period <= merge16(upper_period, wdata_reg, wstrb_reg);
    end
  end

  // ----------------------------------------------------------------
  // Clock pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lpin_sync <= 3'h0;
      upin_sync <= 3'h0;
      lpin_lvl <= 1'b0;
      upin_lvl <= 1'b0;
    end
    else
    begin
      lpin_sync <= {lpin_sync[1:0], lower_ext_clock_pin};
      upin_sync <= {upin_sync[1:0], upper_ext_clock_pin};
      if (lpin_sync[1] == lpin_sync[2])
        lpin_lvl <= lpin_sync[2];
      if (upin_sync[1] == upin_sync[2])
        upin_lvl <= upin_sync[2];
    end
  end

  assign lpin_rise = lpin_sync[1] & lpin_sync[2] & ~lpin_lvl;
  assign upin_rise = upin_sync[1] & upin_sync[2] & ~upin_lvl;

  // ----------------------------------------------------------------
  // Time base stepping
  // ----------------------------------------------------------------
  // RULE_05 cascade select
  assign cascade_sel = lower_ctrl_reg[CASC_BIT];
  // RULE_06 RULE_03 source and gate
  assign lower_src = lower_ctrl_reg[SRC_BIT] ? lpin_rise
    : (~lower_ctrl_reg[GATE_BIT] | lpin_lvl);
  // RULE_09 upper own source
  assign upper_src = upper_ctrl_reg[SRC_BIT] ? upin_rise
    : (~upper_ctrl_reg[GATE_BIT] | upin_lvl);

  // RULE_04 prescalers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lower_pre_reg <= 8'h00;
      upper_pre_reg <= 8'h00;
    end
    else
    begin
      if (!lower_ctrl_reg[RUN_BIT])
        lower_pre_reg <= 8'h00;
      else if (lower_src)
        lower_pre_reg <= lower_tick ? 8'h00 : lower_pre_reg + 8'h01;
      if (!upper_ctrl_reg[RUN_BIT] || cascade_sel)
        upper_pre_reg <= 8'h00;
      else if (upper_src)
        upper_pre_reg <= upper_tick ? 8'h00 : upper_pre_reg + 8'h01;
    end
  end

  assign lower_tick = lower_src
    && lower_pre_reg == div_limit(lower_ctrl_reg[DIV_HI:DIV_LO]);
  assign upper_tick = upper_src
    && upper_pre_reg == div_limit(upper_ctrl_reg[DIV_HI:DIV_LO]);

  // RULE_01 RULE_02 RULE_08 lower run and idle halt
  assign lower_step = lower_ctrl_reg[RUN_BIT] & lower_tick & ~(cpu_idle
    & (lower_ctrl_reg[IDLE_BIT]
       | (cascade_sel & upper_ctrl_reg[IDLE_BIT])));
  // RULE_07 upper controls ignored in cascade
  assign upper_step = ~cascade_sel & upper_ctrl_reg[RUN_BIT] & upper_tick
    & ~(cpu_idle & upper_ctrl_reg[IDLE_BIT]);
  // RULE_23 RULE_21 period compare
  assign lower_match = lower_step & (cascade_sel
    ? {upper_count, lower_count} == {upper_period, lower_period}
    : lower_count == lower_period);
  assign upper_match = upper_step & (upper_count == upper_period);

  // Counts: bus writes override counting
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lower_count <= COUNT_RST;
      upper_count <= COUNT_RST;
    end
    else
    begin
      // RULE_21 RULE_23 cascaded count
      if (lower_match)
      begin
        lower_count <= COUNT_RST;
        if (cascade_sel)
          upper_count <= COUNT_RST;
      end
      else if (lower_step)
      begin
        lower_count <= lower_count + 16'h0001;
        if (cascade_sel && lower_count == 16'hFFFF)
          upper_count <= upper_count + 16'h0001;
      end
      if (upper_match)
        upper_count <= COUNT_RST;
      else if (upper_step)
        upper_count <= upper_count + 16'h0001;
      if (wr_fire && waddr_reg == LOWER_COUNT_OFS)
        lower_count <= merge16(lower_count, wdata_reg, wstrb_reg);
      if (wr_fire && waddr_reg == UPPER_COUNT_OFS)
        upper_count <= merge16(upper_count, wdata_reg, wstrb_reg);
    end
  end

  // Period flags, write one to clear, set wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lower_flag_reg <= 1'b0;
      upper_flag_reg <= 1'b0;
    end
    else
    begin
      if (wr_fire && waddr_reg == STATUS_OFS && wstrb_reg[0])
      begin
        if (wdata_reg[LOWER_FLAG_BIT])
          lower_flag_reg <= 1'b0;
        if (wdata_reg[UPPER_FLAG_BIT])
          upper_flag_reg <= 1'b0;
      end
      if (lower_match && !cascade_sel)
        lower_flag_reg <= 1'b1;
      // RULE_22 cascade flag
      if ((lower_match && cascade_sel) || upper_match)
        upper_flag_reg <= 1'b1;
    end
  end

  assign wake_req = |cap_wake;

  // ----------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCAP; g++)
  begin : g_cap
    logic [15:0] ctrl_reg;
    logic [15:0] fifo_mem [4];
    logic [1:0] wr_ptr, rd_ptr;
    logic [2:0] fill;
    logic ovf_reg;
    logic [2:0] psync;
    logic plvl, prise, pfall, ev, push, pop, ctrl_wr, flag_clr;
    logic [3:0] edge_cnt;
    logic [1:0] ev_cnt;
    logic [2:0] mode;
    logic halted, sleepy;

    assign mode = ctrl_reg[2:0];
    assign ctrl_wr = wr_fire
      && waddr_reg == CAP_BASE_OFS + 8'(g) * CAP_STRIDE;
    assign flag_clr = wr_fire && waddr_reg == STATUS_OFS
      && wstrb_reg[1] && wdata_reg[CAP_FLAG_BIT + g];
    assign pop = rd_fire && fill != 3'h0 && s_axi_araddr
      == CAP_BASE_OFS + 8'(g) * CAP_STRIDE + CAP_BUF_OFS;
    assign sleepy = cpu_idle | cpu_sleep;
    // RULE_19 channel idle halt
    assign halted = cpu_idle & ctrl_reg[CAP_IDLE_BIT];
    assign prise = psync[1] & psync[2] & ~plvl;
    assign pfall = ~psync[1] & ~psync[2] & plvl;

    // RULE_11 qualifying events
    always_comb
    begin
      case (mode)
        TPIC_CAP_ANY: ev = prise | pfall;
        TPIC_CAP_FALL: ev = pfall;
        TPIC_CAP_RISE: ev = prise;
        TPIC_CAP_RISE4: ev = prise && edge_cnt[1:0] == EDGE4_LIM[1:0];
        TPIC_CAP_RISE16: ev = prise && edge_cnt == EDGE16_LIM;
        default: ev = 1'b0;
      endcase
      ev = ev & ~halted;
    end
    // RULE_18 RULE_24 push only when room
    assign push = ev && fill != 3'h4;
    // RULE_20 RULE_12 wake on pin event
    assign cap_wake[g] = sleepy
      & (ev | (mode == TPIC_CAP_WAKE && prise));

    // Pin synchroniser and prescale edge count
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        psync <= 3'h0;
        plvl <= 1'b0;
        edge_cnt <= 4'h0;
      end
      else
      begin
        psync <= {psync[1:0], capture_pin[g]};
        if (psync[1] == psync[2])
          plvl <= psync[2];
        if (ctrl_wr)
          edge_cnt <= 4'h0;
        else if (prise && !halted)
          edge_cnt <= edge_cnt + 4'h1;
      end
    end

    // Control register keeps writable bits only
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        ctrl_reg <= CTRL_RST;
      else if (ctrl_wr)
        ctrl_reg <= merge16(ctrl_reg, wdata_reg, wstrb_reg)
          & ~(16'h0001 << OVF_BIT) & ~(16'h0001 << BNE_BIT) & 16'h20E7;
    end

    // RULE_10 RULE_15 RULE_25 FIFO and overflow
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        fill <= 3'h0;
        ovf_reg <= 1'b0;
      end
      else if (mode == TPIC_CAP_OFF)
      begin
        wr_ptr <= 2'h0;
        rd_ptr <= 2'h0;
        fill <= 3'h0;
        ovf_reg <= 1'b0;
      end
      else
      begin
        if (push)
        begin
          fifo_mem[wr_ptr] <= ctrl_reg[CAP_BASE_BIT] ? lower_count
            : upper_count;
          wr_ptr <= wr_ptr + 2'h1;
        end
        if (pop)
          rd_ptr <= rd_ptr + 2'h1;
        fill <= fill + {2'h0, push} - {2'h0, pop};
        // RULE_16 RULE_24 overflow, cleared once drained
        if (ev && fill == 3'h4)
          ovf_reg <= 1'b1;
        else if (pop && fill == 3'h1)
          ovf_reg <= 1'b0;
      end
    end

    // RULE_13 RULE_14 interrupt spacing, set wins over clear
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        ev_cnt <= 2'h0;
        cap_flag_reg[g] <= 1'b0;
      end
      else
      begin
        if (flag_clr)
          cap_flag_reg[g] <= 1'b0;
        if (ctrl_wr)
          ev_cnt <= 2'h0;
        else if (ev)
        begin
          if (mode == TPIC_CAP_ANY || ev_cnt == ctrl_reg[SPC_HI:SPC_LO])
          begin
            ev_cnt <= 2'h0;
            cap_flag_reg[g] <= 1'b1;
          end
          else
            ev_cnt <= ev_cnt + 2'h1;
        end
        if (mode == TPIC_CAP_WAKE && prise && sleepy)
          cap_flag_reg[g] <= 1'b1;
      end
    end

    // RULE_17 read view
    always_comb
    begin
      cap_ctrl_rd[g] = ctrl_reg;
      cap_ctrl_rd[g][OVF_BIT] = ovf_reg;
      cap_ctrl_rd[g][BNE_BIT] = fill != 3'h0;
      cap_buf_rd[g] = fifo_mem[rd_ptr];
    end
  end

endmodule

//--- core/tpic_pkg.sv
// Purpose: Constants for the timer pair with input capture channels
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: All register fields sit in the low 16 bits of a word
//
// Summary of operation
// RULE_01 - Lower run bit starts cascaded 32-bit timer, else lower timer.
// RULE_02 - Timer idle-halt bit set stops that timer in Idle mode.
// RULE_03 - Gated accumulation only with internal clock and gate enabled.
// RULE_04 - Prescale field 11/10/01/00 divides by 256/64/8/1.
// RULE_05 - Cascade bit joins both timers into one 32-bit timer.
// RULE_06 - Clock-source bit picks external pin rising edge or internal.
// RULE_07 - In cascade mode upper run, gate, prescale, source ignored.
// RULE_08 - Software clears upper idle-halt to keep cascade running in Idle.
// RULE_09 - In 16-bit mode upper timer has own run and clock choice.
// RULE_10 - Each qualifying pin event records selected 16-bit count.
// RULE_11 - Mode field picks 16th, 4th, rising, falling, every edge, off.
// RULE_12 - Mode 111 is rising-edge wake source in Sleep or Idle only.
// RULE_13 - Spacing field flags interrupt every 1st to 4th capture.
// RULE_14 - Every-edge mode flags interrupt on each capture.
// RULE_15 - Base select 1 captures lower count, 0 upper count.
// RULE_16 - Read-only overflow flag, cleared by hardware, shows overflow.
// RULE_17 - Read-only flag shows buffer holds at least one value.
// RULE_18 - Each channel holds captures in a four-word FIFO.
// RULE_19 - Channel idle-halt bit set stops the channel in Idle mode.
// RULE_20 - A capture pin event wakes the device from Sleep or Idle.
// RULE_21 - Lower timer is low word, upper is high word in cascade.
// RULE_22 - Cascaded period match raises the upper timer flag.
// RULE_23 - Timer returns to zero after count equals its period.
// RULE_24 - Capture into a full buffer is dropped and sets overflow.
// RULE_25 - Mode off empties buffer and clears overflow and nonempty.
package tpic_pkg;
  // Register byte offsets
  localparam logic [7:0] LOWER_CTRL_OFS = 8'h00;
  localparam logic [7:0] UPPER_CTRL_OFS = 8'h04;
  localparam logic [7:0] LOWER_COUNT_OFS = 8'h08;
  localparam logic [7:0] UPPER_COUNT_OFS = 8'h0C;
  localparam logic [7:0] LOWER_PERIOD_OFS = 8'h10;
  localparam logic [7:0] UPPER_PERIOD_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] CAP_BASE_OFS = 8'h20;
  localparam logic [7:0] CAP_STRIDE = 8'h08;
  localparam logic [7:0] CAP_BUF_OFS = 8'h04;
  // Timer control fields
  localparam int RUN_BIT = 15;
  localparam int IDLE_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int DIV_HI = 5;
  localparam int DIV_LO = 4;
  localparam int CASC_BIT = 3;
  localparam int SRC_BIT = 1;
  localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;
  // Capture control fields
  localparam int CAP_IDLE_BIT = 13;
  localparam int CAP_BASE_BIT = 7;
  localparam int SPC_HI = 6;
  localparam int SPC_LO = 5;
  localparam int OVF_BIT = 4;
  localparam int BNE_BIT = 3;
  // Status fields
  localparam int LOWER_FLAG_BIT = 0;
  localparam int UPPER_FLAG_BIT = 1;
  localparam int CAP_FLAG_BIT = 8;
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  // Prescale terminal counts (divide minus one)
  localparam logic [7:0] DIV1_LIM = 8'h00;
  localparam logic [7:0] DIV8_LIM = 8'h07;
  localparam logic [7:0] DIV64_LIM = 8'h3F;
  localparam logic [7:0] DIV256_LIM = 8'hFF;
  // Edge count terminal values in prescaled modes (rising edges per capture minus one)
  localparam logic [3:0] EDGE4_LIM = 4'h3;
  localparam logic [3:0] EDGE16_LIM = 4'hF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Capture modes
  typedef enum logic [2:0] {
    TPIC_CAP_OFF = 3'h0,
    TPIC_CAP_ANY = 3'h1,
    TPIC_CAP_FALL = 3'h2,
    TPIC_CAP_RISE = 3'h3,
    TPIC_CAP_RISE4 = 3'h4,
    TPIC_CAP_RISE16 = 3'h5,
    TPIC_CAP_DIS = 3'h6,
    TPIC_CAP_WAKE = 3'h7
  } tpic_cap_mode_t;
endpackage

//--- verif/tpic_props.sv
// Purpose: Port checks for the timer capture block
// Assumes: One clock, synchronous active-low reset
// Notes: Attached by the bind below
`timescale 1ns/10ps
module tpic_props
  import tpic_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic cpu_idle,
  input logic cpu_sleep,
  input logic wake_req
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------
  // Assertions
  // ----------
  chk_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready) else $error("no read answer");
  chk_r_drop: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("rvalid stuck");
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("no write answer");
  chk_word_width: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
  chk_bad_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'hFC |=> s_axi_rresp == RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read");
  chk_wake_cause: assert property (wake_req |->
    cpu_idle || cpu_sleep) else $error("wake while awake");
  chk_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake too long");
endmodule
bind tpic_timer_capture tpic_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .cpu_idle, .cpu_sleep, .wake_req
);

//--- verif/tpic_pin_model.sv
// Purpose: Drives timer clock and capture pins
// Assumes: Pins idle low between pulses
// Notes: Each pulse holds high and low for 4 cycles
`timescale 1ns/10ps
module tpic_pin_model
(
  input logic aclk,
  output logic [3:0] pins
);
  initial pins = 4'h0;
  task automatic pulse(input int s, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      pins[s] <= 1'h1;
      repeat (4) @(posedge aclk);
      pins[s] <= 1'h0;
      repeat (3) @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for the timer capture block
// Assumes: Pin model drives the far side
// Notes: Table first, then hand-written cases
`timescale 1ns/10ps
module tb;
  import tpic_pkg::*;
  typedef struct {
    logic [7:0] wa;
    logic [15:0] wd;
    int n;
    logic [7:0] ra;
    logic [15:0] ex;
  } tpic_row_t;
  localparam logic [7:0] LC = LOWER_CTRL_OFS;
  localparam logic [7:0] CN = LOWER_COUNT_OFS;
  localparam logic [7:0] ST = STATUS_OFS;
  localparam logic [7:0] C0 = CAP_BASE_OFS;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic cpu_idle = 1'h0, cpu_sleep = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, wakes = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, wake_req;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrv, wrv;
  logic [3:0] pins;
  int err_count = 0, total_checks = 0;
  tpic_row_t rows [18] = '{
    '{LC, 16'h8002, 5, CN, 16'h0005}, '{LC, 16'h0002, 3, CN, 16'h0000},
    '{LC, 16'h8052, 16, CN, 16'h0002}, '{LC, 16'h8022, 128, CN, 16'h0002},
    '{LC, 16'h8032, 256, CN, 16'h0001}, '{C0, 16'h0081, 2, C0, 16'h0089},
    '{C0, 16'h0081, 3, C0, 16'h0099}, '{C0, 16'h0082, 1, C0, 16'h008A},
    '{C0, 16'h0083, 5, C0, 16'h009B}, '{C0, 16'h0084, 3, C0, 16'h0084},
    '{C0, 16'h0084, 4, C0, 16'h008C}, '{C0, 16'h0085, 16, C0, 16'h008D},
    '{C0, 16'h0086, 4, C0, 16'h0086}, '{C0, 16'h0080, 4, C0, 16'h0080},
    '{C0, 16'h0087, 2, C0, 16'h0087}, '{C0, 16'h00A3, 1, ST, 16'h0000},
    '{C0, 16'h00A3, 2, ST, 16'h0100}, '{C0, 16'h00E1, 1, ST, 16'h0100}
  };
  initial forever #25 aclk = ~aclk;
  tpic_timer_capture DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_idle, .cpu_sleep,
    .lower_ext_clock_pin(pins[0]), .upper_ext_clock_pin(pins[1]),
    .capture_pin(pins[3:2]), .wake_req
  );
  tpic_pin_model P (.aclk, .pins);
  // Wake pulse counter
  always @(posedge aclk)
    if (wake_req === 1'h1)
      wakes <= wakes + 8'h01;
  task automatic chk(input string s, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One AXI4-Lite write or read, bounded wait
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
      if (s_axi_arready === 1'h1 && !w)
        s_axi_arvalid <= 1'h0;
      if ((w ? s_axi_bvalid : s_axi_rvalid) === 1'h1)
      begin
        wrv = s_axi_bresp;
        rdv = s_axi_rdata;
        rrv = s_axi_rresp;
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        return;
      end
    end
    chk("bus wait", 32'h1, 32'h0);
    close_out();
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    bus(1'h0, a, 32'h0);
    chk("read", {16'h0, e}, rdv);
  endtask
  // Main sequence
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 18; i++)
    begin
      bus(1'h1, CN, 32'h0);
      bus(1'h1, ST, 32'hFFFF);
      bus(1'h1, rows[i].wa, {16'h0, rows[i].wd});
      P.pulse((rows[i].wa == LC) ? 0 : 2, rows[i].n);
      rchk(rows[i].ra, rows[i].ex);
      bus(1'h1, rows[i].wa, 32'h0);
      $display("row %0d done", i);
    end
    bus(1'h1, ST, 32'hFFFF);
    bus(1'h1, LOWER_PERIOD_OFS, 32'h3);
    bus(1'h1, CN, 32'h0);
    bus(1'h1, LC, 32'h8002);
    P.pulse(0, 6);
    rchk(CN, 16'h0002);
    rchk(ST, 16'h0001);
    bus(1'h1, UPPER_PERIOD_OFS, 32'h0);
    bus(1'h1, LC, 32'h800A);
    P.pulse(0, 2);
    rchk(ST, 16'h0003);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(LOWER_PERIOD_OFS, PERIOD_RST);
    rchk(ST, 16'h0000);
    rchk(CN, COUNT_RST);
    bus(1'h0, 8'hFC, 32'h0);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rrv});
    bus(1'h1, 8'hFC, 32'h0);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, wrv});
    $display("reset test done");
    bus(1'h1, CN, 32'hFFFE);
    bus(1'h1, UPPER_CTRL_OFS, 32'h8030);
    bus(1'h1, LC, 32'h800A);
    P.pulse(0, 3);
    bus(1'h1, LC, 32'h0);
    bus(1'h1, UPPER_CTRL_OFS, 32'h0);
    rchk(CN, 16'h0001);
    rchk(UPPER_COUNT_OFS, 16'h0001);
    bus(1'h1, CN, 32'h1234);
    bus(1'h1, UPPER_COUNT_OFS, 32'h5678);
    bus(1'h1, C0, 32'h0083);
    P.pulse(2, 1);
    bus(1'h1, C0, 32'h0003);
    P.pulse(2, 1);
    rchk(C0 + CAP_BUF_OFS, 16'h1234);
    rchk(C0 + CAP_BUF_OFS, 16'h5678);
    rchk(C0, 16'h0003);
    bus(1'h1, UPPER_CTRL_OFS, 32'h8002);
    P.pulse(1, 2);
    rchk(UPPER_COUNT_OFS, 16'h567A);
    $display("cascade and capture done");
    cpu_idle <= 1'h1;
    bus(1'h1, CN, 32'h0);
    bus(1'h1, LC, 32'hA002);
    P.pulse(0, 3);
    rchk(CN, 16'h0000);
    bus(1'h1, LC, 32'h8002);
    P.pulse(0, 3);
    rchk(CN, 16'h0003);
    bus(1'h1, C0, 32'h2083);
    P.pulse(2, 1);
    rchk(C0, 16'h2083);
    bus(1'h1, C0, 32'h0007);
    P.pulse(2, 1);
    chk("wake", 32'h1, {24'h0, wakes});
    cpu_idle <= 1'h0;
    cpu_sleep <= 1'h1;
    P.pulse(2, 1);
    chk("sleep wake", 32'h2, {24'h0, wakes});
    cpu_sleep <= 1'h0;
    $display("idle test done");
    close_out();
  end
endmodule
